// ### cmd_obj_if.sv
`default_nettype none
interface cmd_obj_if;
    logic                   wrEn;
    logic [2:0]             wrIdx;
    logic [1:0]             wrByteEn;
    flash_cmd_pkg::cmd_word_t wrData;
    logic [2:0]             rdIdx;
    flash_cmd_pkg::cmd_word_t rdData;
    flash_cmd_pkg::cmd_word_t word0;
    flash_cmd_pkg::cmd_word_t word1;
    modport ctrl (output wrEn, output wrIdx, output wrByteEn, output wrData,
                  output rdIdx, input rdData, input word0, input word1);
    modport mem  (input wrEn, input wrIdx, input wrByteEn, input wrData,
                  input rdIdx, output rdData, output word0, output word1);
endinterface
`default_nettype wire

// ### cmd_obj_mem.sv
`include "flash_cmd_consts.svh"
`default_nettype none
module cmd_obj_mem (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    cmd_obj_if.mem    port
);
    flash_cmd_pkg::cmd_word_t words [`CMD_WORDS];
    flash_cmd_pkg::cmd_word_t rdData_r;

    // Six 16-bit words, each half written on its own lane
    genvar g;
    generate
        for (g = 0; g < `CMD_WORDS; g++) begin : gWord
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    words[g] <= 16'h0000;
                end else if (ce && port.wrEn && port.wrIdx == 3'(g)) begin // R3
                    if (port.wrByteEn[0]) begin // R4
                        words[g][7:0] <= port.wrData[7:0];
                    end
                    if (port.wrByteEn[1]) begin // R4
                        words[g][15:8] <= port.wrData[15:8];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_r <= 16'h0000;
        end else if (ce) begin
            rdData_r <= (port.rdIdx < 3'(`CMD_WORDS)) ? words[port.rdIdx] : 16'h0000; // R3
        end
    end

    assign port.rdData = rdData_r;
    assign port.word0  = words[0];
    assign port.word1  = words[1];
endmodule // cmd_obj_mem
`default_nettype wire

// ### flash_cmd_consts.svh
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH
// Byte offsets of the AXI4-Lite register map
`define OFF_TIMEBASE_DIV   8'h00
`define OFF_CMD_INDEX      8'h04
`define OFF_STATUS         8'h08
`define OFF_PROTECT_CFG    8'h0c
`define OFF_CMD_WINDOW     8'h10
`define OFF_IRQ_MASK       8'h14
`define OFF_VERSION        8'h18
// Status register bit positions
`define ST_COMPLETE        7
`define ST_ACCESS_ERROR_FLAG          5
`define ST_PVIOL           4
// Interrupt status bit positions (same layout in mask)
`define IRQ_DONE           0
`define IRQ_ACCESS_ERROR_FLAG         1
`define IRQ_PVIOL          2
// Protection window
`define PROT_ENABLE_BIT    7
`define PROT_BASE_ADDR     18'h04400
`define PROT_STEP_SHIFT    8
// Timebase divider
`define DIV_LOADED_BIT     7
`define DIV_WIDTH          7
// Command object
`define CMD_WORDS          6
`define CMD_IDX_W          3
// Version word
`define VERSION_ADDR       18'h040b6
`define VERSION_NUM        4'h1
// Memory controller response: command codes treated as program/erase
`define CMD_CODE_LSB       8
`define CMD_CODE_W         8
`define CMD_PGM_LO         8'h06
`define CMD_PGM_HI         8'h12
// Command execution time, ns, and derived cycle count at 50 MHz
`define CLK_PERIOD_NS      20
`define CMD_EXEC_NS        200
`define CMD_EXEC_CYC       ((`CMD_EXEC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### flash_cmd_pkg.sv
`default_nettype none
package flash_cmd_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CHECK,
        SEQ_EXEC,
        SEQ_DONE
    } seq_state_t;
    typedef logic [15:0] cmd_word_t;
endpackage
`default_nettype wire

// ### flash_command_protect_ctrl.sv
// Operation
// R1: One enable bit turns data-flash program/erase protection on or off.
// R2: Size field protects base upward, (size+1)*256 bytes.
// R3: Command object is six 16-bit words chosen by the index register.
// R4: Command window allows byte writes to either half and word accesses.
// R5: Writing 1 to complete flag clears it and launches the command.
// R6: Object handed over; flag stays 0 until done, then returns to 1.
// R7: While flag is 0, new launches and command window writes are ignored.
// R8: Any divider write sets loaded flag; flag reads 0 from reset. Code sets the flag only on divider writes with wStrb_r[0] high.
// R9: Program/erase without divider loaded does not run; access error set.
// R10: Software loads divider for about 1 MHz timebase after each reset.
// R11: Software avoids program/erase with bus clock below 0.8 MHz.
// R12: Software clears error flags and checks completion before launch.
// R13: Software avoids flash register writes while a command runs.
// R14: Every valid command entered by the sequence is launched.
// R15: Version word at fixed address; low nibble holds the version number.
// R16: Enable bit high enables protection, low disables it.
// R17: Program/erase into protected window does not run; violation flag set.
`include "flash_cmd_consts.svh"
`default_nettype none
module flash_command_protect_ctrl (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             irq
);
    cmd_obj_if cobj ();

    cmd_obj_mem uMem (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .port (cobj)
    );

    // Write and read channel capture
    logic                     awHeld_r;
    logic [7:0]               awAddr_r;
    logic                     wHeld_r;
    logic [31:0]              wData_r;
    logic [3:0]               wStrb_r;
    logic                     bvalid_r;
    logic                     arHeld_r;
    logic [7:0]               arAddr_r;
    logic                     rvalid_r;
    logic [31:0]              rdata_r;
    logic [1:0]               rresp_r;
    logic [1:0]               bresp_r;
    logic                     rdPend_r;

    // Block state
    logic [`DIV_WIDTH-1:0]    divider_r;
    logic                     divLoaded_r;
    logic [2:0]               cmdIndex_r;
    logic                     complete_r;
    logic                     access_error_flag_r;
    logic                     protViol_r;
    logic                     protEnable_r;
    logic [3:0]               protSize_r;
    logic [2:0]               irqStat_r;
    logic [2:0]               irqMask_r;
    logic [7:0]               execCnt_r;
    flash_cmd_pkg::seq_state_t state_r;

    logic                     doWrite;
    logic                     wrDiv;
    logic                     wrIdx;
    logic                     wrStat;
    logic                     wrProt;
    logic                     wrWin;
    logic                     wrMask;
    logic                     launch;
    logic                     isPgmErase;
    logic [17:0]              targetAddr;
    logic [17:0]              protTop;
    logic                     inProt;
    logic                     setDone;
    logic                     setAcc;
    logic                     setViol;

    assign awready = ce && !awHeld_r && !bvalid_r;
    assign wready  = ce && !wHeld_r && !bvalid_r;
    assign arready = ce && !arHeld_r && !rdPend_r && !rvalid_r;
    assign doWrite = ce && awHeld_r && wHeld_r && !bvalid_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wHeld_r  <= 1'b0;
            wData_r  <= 32'h00000000;
            wStrb_r  <= 4'h0;
        end else if (ce) begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= awaddr;
            end else if (doWrite) begin
                awHeld_r <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end else if (doWrite) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= 2'b00;
        end else if (ce) begin
            if (doWrite) begin
                bvalid_r <= 1'b1;
                bresp_r  <= (awAddr_r[7:2] > `OFF_VERSION >> 2) ? 2'b10 : 2'b00;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Register write decode; unmapped offsets answer SLVERR
    assign wrDiv  = doWrite && awAddr_r[7:2] == 6'(`OFF_TIMEBASE_DIV >> 2) && wStrb_r[0];
    assign wrIdx  = doWrite && awAddr_r[7:2] == 6'(`OFF_CMD_INDEX >> 2) && wStrb_r[0];
    assign wrStat = doWrite && awAddr_r[7:2] == 6'(`OFF_STATUS >> 2) && wStrb_r[0];
    assign wrProt = doWrite && awAddr_r[7:2] == 6'(`OFF_PROTECT_CFG >> 2) && wStrb_r[0];
    assign wrWin  = doWrite && awAddr_r[7:2] == 6'(`OFF_CMD_WINDOW >> 2);
    assign wrMask = doWrite && awAddr_r[7:2] == 6'(`OFF_IRQ_MASK >> 2) && wStrb_r[0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            divider_r   <= '0;
            divLoaded_r <= 1'b0;
        end else if (ce && wrDiv) begin
            divider_r   <= wData_r[`DIV_WIDTH-1:0];
            divLoaded_r <= 1'b1; // R8
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdIndex_r   <= 3'h0;
            protEnable_r <= 1'b0;
            protSize_r   <= 4'h0;
            irqMask_r    <= 3'h0;
        end else if (ce) begin
            if (wrIdx) begin
                cmdIndex_r <= wData_r[2:0];
            end
            if (wrProt) begin
                protEnable_r <= wData_r[`PROT_ENABLE_BIT]; // R1 R16
                protSize_r   <= wData_r[3:0];
            end
            if (wrMask) begin
                irqMask_r <= wData_r[2:0];
            end
        end
    end

    // Window writes dropped while a command runs
    assign cobj.wrEn     = wrWin && complete_r && (|wStrb_r[1:0]); // R7
    assign cobj.wrIdx    = cmdIndex_r; // R3
    assign cobj.wrByteEn = wStrb_r[1:0]; // R4
    assign cobj.wrData   = wData_r[15:0];
    assign cobj.rdIdx    = cmdIndex_r;

    // Launch only from idle with completion set
    assign launch = wrStat && wData_r[`ST_COMPLETE] && complete_r
                    && state_r == flash_cmd_pkg::SEQ_IDLE; // R5 R7 R14

    assign isPgmErase = cobj.word0[`CMD_CODE_LSB +: `CMD_CODE_W] >= `CMD_PGM_LO
                     && cobj.word0[`CMD_CODE_LSB +: `CMD_CODE_W] <= `CMD_PGM_HI;
    assign targetAddr = {cobj.word0[1:0], cobj.word1};
    assign protTop    = `PROT_BASE_ADDR + ({14'h0000, protSize_r} + 18'h00001 << `PROT_STEP_SHIFT);
    assign inProt     = protEnable_r && targetAddr >= `PROT_BASE_ADDR && targetAddr < protTop; // R1 R2 R16

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r   <= flash_cmd_pkg::SEQ_IDLE;
            execCnt_r <= 8'h00;
        end else if (ce) begin
            unique case (state_r)
                flash_cmd_pkg::SEQ_IDLE: begin
                    if (launch) begin
                        state_r <= flash_cmd_pkg::SEQ_CHECK; // R6
                    end
                end
                flash_cmd_pkg::SEQ_CHECK: begin
                    if (isPgmErase && (!divLoaded_r || inProt)) begin
                        state_r <= flash_cmd_pkg::SEQ_DONE; // R9 R17
                    end else begin
                        state_r   <= flash_cmd_pkg::SEQ_EXEC; // R14
                        execCnt_r <= 8'(`CMD_EXEC_CYC - 1);
                    end
                end
                flash_cmd_pkg::SEQ_EXEC: begin
                    if (execCnt_r == 8'h00) begin
                        state_r <= flash_cmd_pkg::SEQ_DONE;
                    end else begin
                        execCnt_r <= execCnt_r - 8'h01;
                    end
                end
                flash_cmd_pkg::SEQ_DONE: begin
                    state_r <= flash_cmd_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    assign setDone = ce && state_r == flash_cmd_pkg::SEQ_DONE;
    assign setAcc  = ce && state_r == flash_cmd_pkg::SEQ_CHECK && isPgmErase && !divLoaded_r;
    assign setViol = ce && state_r == flash_cmd_pkg::SEQ_CHECK && isPgmErase && divLoaded_r
                     && inProt;

    // Error flags: hardware set wins over a write-one clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            complete_r <= 1'b1;
            access_error_flag_r   <= 1'b0;
            protViol_r <= 1'b0;
        end else if (ce) begin
            if (launch) begin
                complete_r <= 1'b0; // R5
            end else if (setDone) begin
                complete_r <= 1'b1; // R6
            end
            if (setAcc) begin
                access_error_flag_r <= 1'b1; // R9
            end else if (wrStat && wData_r[`ST_ACCESS_ERROR_FLAG]) begin
                access_error_flag_r <= 1'b0;
            end
            if (setViol) begin
                protViol_r <= 1'b1; // R17
            end else if (wrStat && wData_r[`ST_PVIOL]) begin
                protViol_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStat_r <= 3'h0;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                if ((i == `IRQ_DONE && setDone) || (i == `IRQ_ACCESS_ERROR_FLAG && setAcc)
                    || (i == `IRQ_PVIOL && setViol)) begin
                    irqStat_r[i] <= 1'b1;
                end else if (wrMask == 1'b0 && doWrite
                             && awAddr_r[7:2] == 6'(`OFF_VERSION >> 2) && wData_r[i]) begin
                    irqStat_r[i] <= 1'b0;
                end
            end
        end
    end
    assign irq = |(irqStat_r & irqMask_r);

    // Read path; window data comes one cycle late from the memory register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arHeld_r <= 1'b0;
            arAddr_r <= 8'h00;
            rdPend_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= 2'b00;
        end else if (ce) begin
            if (arvalid && arready) begin
                arHeld_r <= 1'b1;
                arAddr_r <= araddr;
            end else if (arHeld_r) begin
                arHeld_r <= 1'b0;
                rdPend_r <= 1'b1;
            end else if (rdPend_r) begin
                rdPend_r <= 1'b0;
                rvalid_r <= 1'b1;
                rresp_r  <= 2'b00;
                unique case (arAddr_r[7:2])
                    6'(`OFF_TIMEBASE_DIV >> 2): rdata_r <= {24'h0, divLoaded_r, divider_r}; // R8
                    6'(`OFF_CMD_INDEX >> 2):    rdata_r <= {29'h0, cmdIndex_r};
                    6'(`OFF_STATUS >> 2):       rdata_r <= {24'h0, complete_r, 1'b0, access_error_flag_r,
                                                             protViol_r, 4'h0};
                    6'(`OFF_PROTECT_CFG >> 2):  rdata_r <= {24'h0, protEnable_r, 3'h0, protSize_r};
                    6'(`OFF_CMD_WINDOW >> 2):   rdata_r <= {16'h0, cobj.rdData}; // R4
                    6'(`OFF_IRQ_MASK >> 2):     rdata_r <= {29'h0, irqMask_r};
                    6'(`OFF_VERSION >> 2):      rdata_r <= {28'h0, `VERSION_NUM}; // R15
                    default: begin
                        rdata_r <= 32'h00000000;
                        rresp_r <= 2'b10;
                    end
                endcase
            end else if (rvalid_r && rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_r;
    assign bresp  = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata  = rdata_r;
    assign rresp  = rresp_r;

    launch_clears_a: assert property (@(posedge clk) disable iff (rst) // R5
        launch |=> !complete_r) else $error("launch did not clear flag");
    busy_holds_a: assert property (@(posedge clk) disable iff (rst) // R6
        launch |=> !complete_r [*2]) else $error("flag returned too early");
    done_within_a: assert property (@(posedge clk) disable iff (rst) // R6
        (launch && ce) |-> ##[2:40] complete_r) else $error("command never completed");
    window_locked_a: assert property (@(posedge clk) disable iff (rst) // R7
        !complete_r |-> !cobj.wrEn) else $error("window written while busy");
    div_flag_a: assert property (@(posedge clk) disable iff (rst) // R8
        wrDiv |=> divLoaded_r) else $error("divider flag not set");
    no_div_err_a: assert property (@(posedge clk) disable iff (rst) // R9
        (ce && state_r == flash_cmd_pkg::SEQ_CHECK && isPgmErase && !divLoaded_r)
        |=> access_error_flag_r && state_r == flash_cmd_pkg::SEQ_DONE)
        else $error("missed access error");
    prot_viol_a: assert property (@(posedge clk) disable iff (rst) // R17
        setViol |=> protViol_r && state_r != flash_cmd_pkg::SEQ_EXEC)
        else $error("protected run");
    prot_off_a: assert property (@(posedge clk) disable iff (rst) // R1 R16
        (ce && state_r == flash_cmd_pkg::SEQ_CHECK && isPgmErase && divLoaded_r && !protEnable_r)
        |=> state_r == flash_cmd_pkg::SEQ_EXEC) else $error("protection active while off");
    irq_level_a: assert property (@(posedge clk) disable iff (rst)
        setDone && irqMask_r[`IRQ_DONE] |=> irq) else $error("done interrupt not raised");
    cmd_run_c: cover property (@(posedge clk) disable iff (rst)
        state_r == flash_cmd_pkg::SEQ_EXEC ##[1:20] setDone);
    acc_err_c: cover property (@(posedge clk) disable iff (rst) setAcc);
    viol_c: cover property (@(posedge clk) disable iff (rst) setViol);
    frozen_c: cover property (@(posedge clk) disable iff (rst)
        !ce && state_r == flash_cmd_pkg::SEQ_EXEC);
endmodule // flash_command_protect_ctrl
`default_nettype wire

// ### test_flash_command_protect_ctrl.sv
`include "flash_cmd_consts.svh"
`default_nettype none
`define CHECK(got, exp) begin \
    checksDone++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module test_flash_command_protect_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b1;
    logic [7:0]  araddr = 8'h00;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b1;
    logic        irq;
    logic        maskOn = 1'b1;
    logic        freezeOn = 1'b0;
    int          fails = 0;
    int          checksDone = 0;
    int          cycles = 0;

    flash_command_protect_ctrl u_dut (
        .clk(clk), .rst(rst), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .irq(irq)
    );

    always #10 clk = ~clk;

    // Ceiling sits well above the longest expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Ready lines drop once an address or data beat is held, so each valid is lowered only after its own handshake
    task automatic axWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            n++;
        end while (!bvalid && n < 200);
        r = bresp;
        if (n >= 200) begin
            fails++;
        end
    endtask

    task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            n++;
        end while (!rvalid && n < 200);
        d = rdata;
        r = rresp;
        if (n >= 200) begin
            fails++;
        end
    endtask

    task automatic cmdRun(input logic [7:0] code, input logic [17:0] addr,
                          input logic expErr, input logic expViol);
        logic [31:0] d;
        logic [1:0]  r;
        logic        ok;
        int          n;
        ok = !(expErr || expViol);
        axWrite(`OFF_CMD_INDEX, 32'h0, 4'h1, r);
        axWrite(`OFF_CMD_WINDOW, {16'h0, code, 6'h0, addr[17:16]}, 4'h3, r);
        axWrite(`OFF_CMD_INDEX, 32'h1, 4'h1, r);
        axWrite(`OFF_CMD_WINDOW, {16'h0, addr[15:0]}, 4'h3, r);
        axWrite(`OFF_CMD_INDEX, 32'h5, 4'h1, r);
        axWrite(`OFF_CMD_WINDOW, 32'h5555, 4'h3, r);
        axWrite(`OFF_STATUS, 32'h80, 4'h1, r);
        if (freezeOn) begin
            // Frozen long past the run time, so the busy check below catches a leak
            ce <= 1'b0;
            repeat (20) @(posedge clk);
            `CHECK({awready, arready}, 2'b00)
            ce <= 1'b1;
        end
        if (ok) begin
            // Deliberate write while busy; it must leave the object alone
            axWrite(`OFF_CMD_WINDOW, 32'h1234, 4'h3, r);
            `CHECK(r, 2'b00)
            axRead(`OFF_STATUS, d, r);
            `CHECK(d[`ST_COMPLETE], 1'b0)
        end
        n = 0;
        do begin
            axRead(`OFF_STATUS, d, r);
            n++;
        end while (d[`ST_COMPLETE] !== 1'b1 && n < 40);
        `CHECK(d[`ST_COMPLETE], 1'b1)
        `CHECK(d[`ST_ACCESS_ERROR_FLAG], expErr)
        `CHECK(d[`ST_PVIOL], expViol)
        `CHECK(irq, maskOn)
        if (ok) begin
            axRead(`OFF_CMD_WINDOW, d, r);
            `CHECK(d[15:0], 16'h5555)
        end
        // Error flags cleared before the next launch
        axWrite(`OFF_STATUS, 32'h30, 4'h1, r);
        axWrite(`OFF_VERSION, 32'h7, 4'h1, r);
        `CHECK(irq, 1'b0)
    endtask

    task automatic tResetAndMap;
        logic [31:0] d;
        logic [1:0]  r;
        axRead(`OFF_TIMEBASE_DIV, d, r);
        `CHECK(d[`DIV_LOADED_BIT], 1'b0)
        axRead(`OFF_STATUS, d, r);
        `CHECK({d[`ST_COMPLETE], d[`ST_ACCESS_ERROR_FLAG], d[`ST_PVIOL]}, 3'b100)
        axRead(`OFF_VERSION, d, r);
        `CHECK(d[3:0], 4'h1)
        `CHECK(irq, 1'b0)
        axWrite(`OFF_PROTECT_CFG, 32'h8f, 4'h1, r);
        `CHECK(r, 2'b00)
        axRead(`OFF_PROTECT_CFG, d, r);
        `CHECK(d[7:0], 8'h8f)
        axRead(8'h1c, d, r);
        `CHECK({r, d}, {2'b10, 32'h0})
        axWrite(8'h20, 32'hff, 4'hf, r);
        `CHECK(r, 2'b10)
    endtask

    task automatic tWindow;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 6; i++) begin
            axWrite(`OFF_CMD_INDEX, 32'(i), 4'h1, r);
            axWrite(`OFF_CMD_WINDOW, 32'h1000 + 32'(i * 16'h0111), 4'h3, r);
        end
        for (int i = 0; i < 6; i++) begin
            axWrite(`OFF_CMD_INDEX, 32'(i), 4'h1, r);
            axRead(`OFF_CMD_WINDOW, d, r);
            `CHECK(d[15:0], 16'h1000 + 16'(i * 16'h0111))
        end
        axWrite(`OFF_CMD_INDEX, 32'h2, 4'h1, r);
        axWrite(`OFF_CMD_WINDOW, 32'haaaa, 4'h3, r);
        axWrite(`OFF_CMD_WINDOW, 32'hff11, 4'h1, r);
        axRead(`OFF_CMD_WINDOW, d, r);
        `CHECK(d[15:0], 16'haa11)
        axWrite(`OFF_CMD_WINDOW, 32'h22ff, 4'h2, r);
        axRead(`OFF_CMD_WINDOW, d, r);
        `CHECK(d[15:0], 16'h2211)
    endtask

    task automatic tDivider;
        logic [31:0] d;
        logic [1:0]  r;
        maskOn = 1'b0;
        axWrite(`OFF_IRQ_MASK, 32'h0, 4'h1, r);
        cmdRun(8'h06, 18'h00100, 1'b1, 1'b0);
        maskOn = 1'b1;
        axWrite(`OFF_IRQ_MASK, 32'h7, 4'h1, r);
        cmdRun(8'h12, 18'h00100, 1'b1, 1'b0);
        // A value of 49 divides the 50 MHz bus clock to about 1 MHz
        axWrite(`OFF_TIMEBASE_DIV, 32'h31, 4'h1, r);
        axRead(`OFF_TIMEBASE_DIV, d, r);
        `CHECK(d[7:0], 8'hb1)
        cmdRun(8'h06, 18'h00100, 1'b0, 1'b0);
        freezeOn = 1'b1;
        cmdRun(8'h01, 18'h00000, 1'b0, 1'b0);
        freezeOn = 1'b0;
    endtask

    task automatic tProtect;
        logic [17:0] top;
        logic [1:0]  r;
        for (int s = 0; s < 16; s++) begin
            top = 18'h04400 + 18'((s + 1) * 256);
            axWrite(`OFF_PROTECT_CFG, 32'h80 | 32'(s), 4'h1, r);
            cmdRun(8'h06, top - 18'h1, 1'b0, 1'b1);
            cmdRun(8'h12, top, 1'b0, 1'b0);
        end
        axWrite(`OFF_PROTECT_CFG, 32'h0f, 4'h1, r);
        cmdRun(8'h06, 18'h04400, 1'b0, 1'b0);
        axWrite(`OFF_PROTECT_CFG, 32'h8f, 4'h1, r);
        cmdRun(8'h12, 18'h04400, 1'b0, 1'b1);
        cmdRun(8'h06, 18'h043ff, 1'b0, 1'b0);
    endtask

    task automatic tSecondReset;
        logic [31:0] d;
        logic [1:0]  r;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        axRead(`OFF_TIMEBASE_DIV, d, r);
        `CHECK(d[`DIV_LOADED_BIT], 1'b0)
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tResetAndMap();
        tWindow();
        tDivider();
        tProtect();
        @(posedge clk);
        tSecondReset();
        report_and_stop();
    end
endmodule // test_flash_command_protect_ctrl
`undef CHECK
`default_nettype wire
